// *** verilog/ptv_image3_map.vh ***
// Register map, field positions and reset values of the third PCI target image.
// Behaviour
// - Single block transfers only in A24/A32 up to 32-bit.
// - A24/A32 with 64-bit width may issue multiplexed blocks.
// - I/O space ignores posting; all transfers coupled.
// - Width field 23:22 encodes 8/16/32/64, resets 32-bit.
// - Space field 18:16 encodes A16, A24, A32, CR/CSR, users.
// - Bit 14 selects data or program code.
// - Bit 12 selects user or supervisor code.
// - Bit 8 permits single block transfers.
// - Bit 0 selects PCI memory or I/O.
// - Base in bits 31:16, 64 KB aligned.
// - Claim from base up to below limit.
// - Zero limit means no upper bound.
// - Remote upper address is PCI plus offset.
`ifndef PTV_IMAGE3_MAP_VH
`define PTV_IMAGE3_MAP_VH

`define PTV_OFS_CONTROL      12'h13c
`define PTV_OFS_BASE         12'h140
`define PTV_OFS_LIMIT        12'h144
`define PTV_OFS_OFFSET       12'h148
`define PTV_OFS_STATUS       12'h14c

`define PTV_BIT_ENABLE       31
`define PTV_BIT_POST         30
`define PTV_WIDTH_HI         23
`define PTV_WIDTH_LO         22
`define PTV_SPACE_HI         18
`define PTV_SPACE_LO         16
`define PTV_BIT_PROGRAM      14
`define PTV_BIT_SUPER        12
`define PTV_BIT_BLOCK        8
`define PTV_BIT_HOST_IO      0
`define PTV_ADDR_HI          31
`define PTV_ADDR_LO          16
`define PTV_STAT_BUSY        0
`define PTV_STAT_MISS        1
`define PTV_STAT_POSTED      2

`define PTV_RST_ENABLE       1'h0
`define PTV_RST_POST         1'h0
`define PTV_RST_WIDTH        2'h2
`define PTV_RST_SPACE        3'h0
`define PTV_RST_PROGRAM      1'h0
`define PTV_RST_SUPER        1'h0
`define PTV_RST_BLOCK        1'h0
`define PTV_RST_HOST_IO      1'h0
`define PTV_RST_WINDOW       16'h0000

`define PTV_WIDTH_8          2'h0
`define PTV_WIDTH_16         2'h1
`define PTV_WIDTH_32         2'h2
`define PTV_WIDTH_64         2'h3
`define PTV_SPACE_A16        3'h0
`define PTV_SPACE_A24        3'h1
`define PTV_SPACE_A32        3'h2
`define PTV_SPACE_CRCSR      3'h5
`define PTV_SPACE_USER1      3'h6
`define PTV_SPACE_USER2      3'h7

`endif

// *** verilog/ptv_window_decode.v ***
// Window compare and upper address translation for one target image.
`timescale 1ns/1ps
module ptv_window_decode (
    input  wire        enable_i,
    input  wire        host_io_i,
    input  wire        req_io_i,
    input  wire [31:0] req_addr_i,
    input  wire [15:0] base_i,
    input  wire [15:0] limit_i,
    input  wire [15:0] offset_i,
    output wire        hit_o,
    output wire [31:0] vme_addr_o
);
    wire [15:0] upper;
    wire        above_base;
    wire        below_limit;

    assign upper       = req_addr_i[31:16];
    assign above_base  = (upper >= base_i);
    assign below_limit = (limit_i == 16'h0000) || (upper < limit_i);
    // The request space must match the chosen host space.
    assign hit_o       = enable_i && (req_io_i == host_io_i) && above_base && below_limit;

    // The sum wraps modulo 2^16, which is the two's complement addition wanted.
    assign vme_addr_o  = {upper + offset_i, req_addr_i[15:0]};
endmodule

// *** verilog/ptv_image3.v ***
// Third PCI target image: register file, window decode and remote cycle attributes.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "ptv_image3_map.vh"
module ptv_image3 (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave.
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // Transactions from the PCI target side.
    input  wire        req_valid_i,
    input  wire [31:0] req_addr_i,
    input  wire        req_io_i,
    input  wire        req_write_i,
    output wire        req_ready_o,
    output wire        pci_claim_o,
    output wire        pci_miss_o,
    output wire        pci_done_o,
    // Cycle request to the remote master engine.
    input  wire        vme_done_i,
    output wire        vme_start_o,
    output wire [31:0] vme_addr_o,
    output wire        vme_write_o,
    output wire [2:0]  vme_space_o,
    output wire [1:0]  vme_width_o,
    output wire        vme_program_o,
    output wire        vme_super_o,
    output wire        vme_blt_o,
    output wire        vme_mblt_o,
    output wire        vme_posted_o
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte lane merge used by every writable register.
    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Register selected by a bus address; returns one-hot, zero when unmapped.
    function [4:0] reg_hit;
        input [11:0] adr;
        begin
            reg_hit = 5'h00;
            case ({adr[11:2], 2'b00})
                `PTV_OFS_CONTROL: reg_hit = 5'h01;
                `PTV_OFS_BASE:    reg_hit = 5'h02;
                `PTV_OFS_LIMIT:   reg_hit = 5'h04;
                `PTV_OFS_OFFSET:  reg_hit = 5'h08;
                `PTV_OFS_STATUS:  reg_hit = 5'h10;
                default:          reg_hit = 5'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    reg        enable_reg;
    reg        post_reg;
    reg [1:0]  width_reg;
    reg [2:0]  space_reg;
    reg        program_reg;
    reg        super_reg;
    reg        block_reg;
    reg        host_io_reg;
    reg [15:0] base_reg;
    reg [15:0] limit_reg;
    reg [15:0] offset_reg;

    // Bus slave state.
    reg        ack_reg;
    reg [31:0] dat_reg;

    // Transaction state.
    reg        state_reg;
    reg        ready_reg;
    reg        claim_reg;
    reg        miss_reg;
    reg        done_reg;
    reg        start_reg;
    reg [31:0] vaddr_reg;
    reg        vwrite_reg;
    reg [2:0]  vspace_reg;
    reg [1:0]  vwidth_reg;
    reg        vprogram_reg;
    reg        vsuper_reg;
    reg        vblt_reg;
    reg        vmblt_reg;
    reg        vposted_reg;
    reg        last_miss_reg;

    wire [31:0] control_word;
    wire [31:0] status_word;
    wire [31:0] control_next;
    wire [31:0] base_next;
    wire [31:0] limit_next;
    wire [31:0] offset_next;
    wire [4:0]  sel_reg;
    wire        bus_req;
    wire        bus_wr;
    wire        take;
    wire        hit;
    wire [31:0] xlate_addr;
    wire        long_space;
    wire        blt_ok;
    wire        mblt_ok;
    wire        posted;

    ////////////////////////////////////////////////////////////////////////////////
    // Register read images; reserved bits read as zero.
    assign control_word = {enable_reg, post_reg, 6'h00,
                           width_reg, 3'h0, space_reg,
                           1'b0, program_reg, 1'b0, super_reg, 3'h0, block_reg,
                           7'h00, host_io_reg};
    assign status_word  = {29'h0, vposted_reg, last_miss_reg, ~ready_reg};

    assign bus_req      = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr       = bus_req && wb_we_i;
    assign sel_reg      = reg_hit(wb_adr_i);

    assign control_next = merge(control_word, wb_dat_i, wb_sel_i);
    assign base_next    = merge({base_reg, 16'h0000}, wb_dat_i, wb_sel_i);
    assign limit_next   = merge({limit_reg, 16'h0000}, wb_dat_i, wb_sel_i);
    assign offset_next  = merge({offset_reg, 16'h0000}, wb_dat_i, wb_sel_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads return zero and writes vanish.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (sel_reg)
                    5'h01:   dat_reg <= control_word;
                    5'h02:   dat_reg <= {base_reg, 16'h0000};
                    5'h04:   dat_reg <= {limit_reg, 16'h0000};
                    5'h08:   dat_reg <= {offset_reg, 16'h0000};
                    5'h10:   dat_reg <= status_word;
                    default: dat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Writes land at the edge where ack is raised toward the master.
    always @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg  <= `PTV_RST_ENABLE;
            post_reg    <= `PTV_RST_POST;
            width_reg   <= `PTV_RST_WIDTH;
            space_reg   <= `PTV_RST_SPACE;
            program_reg <= `PTV_RST_PROGRAM;
            super_reg   <= `PTV_RST_SUPER;
            block_reg   <= `PTV_RST_BLOCK;
            host_io_reg <= `PTV_RST_HOST_IO;
            base_reg    <= `PTV_RST_WINDOW;
            limit_reg   <= `PTV_RST_WINDOW;
            offset_reg  <= `PTV_RST_WINDOW;
        end else if (bus_wr) begin
            if (sel_reg[0]) begin
                enable_reg  <= control_next[`PTV_BIT_ENABLE];
                post_reg    <= control_next[`PTV_BIT_POST];
                width_reg   <= control_next[`PTV_WIDTH_HI:`PTV_WIDTH_LO];
                space_reg   <= control_next[`PTV_SPACE_HI:`PTV_SPACE_LO];
                program_reg <= control_next[`PTV_BIT_PROGRAM];
                super_reg   <= control_next[`PTV_BIT_SUPER];
                block_reg   <= control_next[`PTV_BIT_BLOCK];
                host_io_reg <= control_next[`PTV_BIT_HOST_IO];
            end
            if (sel_reg[1]) begin
                base_reg <= base_next[`PTV_ADDR_HI:`PTV_ADDR_LO];
            end
            if (sel_reg[2]) begin
                limit_reg <= limit_next[`PTV_ADDR_HI:`PTV_ADDR_LO];
            end
            if (sel_reg[3]) begin
                offset_reg <= offset_next[`PTV_ADDR_HI:`PTV_ADDR_LO];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Window decode and cycle attributes.
    ptv_window_decode u_decode (
        .enable_i   (enable_reg),
        .host_io_i  (host_io_reg),
        .req_io_i   (req_io_i),
        .req_addr_i (req_addr_i),
        .base_i     (base_reg),
        .limit_i    (limit_reg),
        .offset_i   (offset_reg),
        .hit_o      (hit),
        .vme_addr_o (xlate_addr)
    );

    // Reserved space codes and A16, CR/CSR, user spaces never carry block cycles.
    assign long_space = (space_reg == `PTV_SPACE_A24) || (space_reg == `PTV_SPACE_A32);
    assign blt_ok     = block_reg && long_space && (width_reg != `PTV_WIDTH_64);
    assign mblt_ok    = long_space && (width_reg == `PTV_WIDTH_64);
    // I/O space always runs coupled, whatever the posting bit holds.
    assign posted     = req_write_i && post_reg && !host_io_reg;

    assign take       = req_valid_i && ready_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Transaction sequencer. Attributes are frozen at claim time so that a
    // register write during a remote cycle cannot corrupt it; one cycle at a
    // time is traded for the lack of any posting buffer.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg     <= ST_IDLE;
            ready_reg     <= 1'b1;
            claim_reg     <= 1'b0;
            miss_reg      <= 1'b0;
            done_reg      <= 1'b0;
            start_reg     <= 1'b0;
            vaddr_reg     <= 32'h0000_0000;
            vwrite_reg    <= 1'b0;
            vspace_reg    <= `PTV_RST_SPACE;
            vwidth_reg    <= `PTV_RST_WIDTH;
            vprogram_reg  <= 1'b0;
            vsuper_reg    <= 1'b0;
            vblt_reg      <= 1'b0;
            vmblt_reg     <= 1'b0;
            vposted_reg   <= 1'b0;
            last_miss_reg <= 1'b0;
        end else begin
            claim_reg <= 1'b0;
            miss_reg  <= 1'b0;
            done_reg  <= 1'b0;
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (take && hit) begin
                        state_reg     <= ST_WAIT;
                        ready_reg     <= 1'b0;
                        claim_reg     <= 1'b1;
                        start_reg     <= 1'b1;
                        done_reg      <= posted;
                        vaddr_reg     <= xlate_addr;
                        vwrite_reg    <= req_write_i;
                        vspace_reg    <= space_reg;
                        vwidth_reg    <= width_reg;
                        vprogram_reg  <= program_reg;
                        vsuper_reg    <= super_reg;
                        vblt_reg      <= blt_ok;
                        vmblt_reg     <= mblt_ok;
                        vposted_reg   <= posted;
                        last_miss_reg <= 1'b0;
                    end else if (take) begin
                        miss_reg      <= 1'b1;
                        last_miss_reg <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (vme_done_i) begin
                        state_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                        // Coupled transfers finish on PCI only now.
                        done_reg  <= !vposted_reg;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    assign req_ready_o   = ready_reg;
    assign pci_claim_o   = claim_reg;
    assign pci_miss_o    = miss_reg;
    assign pci_done_o    = done_reg;
    assign vme_start_o   = start_reg;
    assign vme_addr_o    = vaddr_reg;
    assign vme_write_o   = vwrite_reg;
    assign vme_space_o   = vspace_reg;
    assign vme_width_o   = vwidth_reg;
    assign vme_program_o = vprogram_reg;
    assign vme_super_o   = vsuper_reg;
    assign vme_blt_o     = vblt_reg;
    assign vme_mblt_o    = vmblt_reg;
    assign vme_posted_o  = vposted_reg;
endmodule

// *** testbench/ptv_image3_props.sv ***
// Port-level assertions for the third PCI target image.
`timescale 1ns/1ps
module ptv_image3_props (
    input logic        clk_i,
    input logic        rst_i,
    input logic        req_valid_i,
    input logic        req_ready_o,
    input logic [31:0] req_addr_i,
    input logic        pci_claim_o,
    input logic        pci_miss_o,
    input logic        pci_done_o,
    input logic        vme_done_i,
    input logic        vme_start_o,
    input logic [31:0] vme_addr_o,
    input logic        vme_write_o,
    input logic [2:0]  vme_space_o,
    input logic [1:0]  vme_width_o,
    input logic        vme_blt_o,
    input logic        vme_mblt_o,
    input logic        vme_posted_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire a24_a32 = vme_space_o == 3'h1 || vme_space_o == 3'h2;
    ////////////////////////////////////////////////////////////////////////////////
    sequence taken_s;
        req_valid_i && req_ready_o;
    endsequence
    sequence claim_s;
        pci_claim_o && vme_start_o && !req_ready_o;
    endsequence
    a_answer_once: assert property (taken_s |=> pci_claim_o != pci_miss_o)
        else $error("request not answered by exactly one of claim and miss");
    a_claim_start: assert property (pci_claim_o |-> claim_s)
        else $error("claim without remote start or with ready high");
    a_block_gate: assert property (vme_blt_o |-> a24_a32 && vme_width_o != 2'h3)
        else $error("block transfer outside A24/A32 up to 32-bit");
    a_multiplex_gate: assert property (vme_mblt_o |-> a24_a32 && vme_width_o == 2'h3)
        else $error("multiplexed block outside A24/A32 64-bit");
    a_posted_write: assert property (vme_posted_o |-> vme_write_o)
        else $error("posting flagged on a read");
    a_posted_done: assert property (claim_s ##0 vme_posted_o |-> pci_done_o)
        else $error("posted write not completed at claim");
    a_coupled_done: assert property (vme_done_i && !req_ready_o && !vme_posted_o
        |=> pci_done_o && req_ready_o)
        else $error("coupled transfer not completed after remote done");
    a_low_bits: assert property (pci_claim_o |->
        vme_addr_o[15:0] == $past(req_addr_i[15:0]))
        else $error("lower address bits altered");
endmodule
bind ptv_image3 ptv_image3_props i_ptv_image3_props (.*);

// *** testbench/ptv_remote_engine.sv ***
// Stand-in for the remote master engine: finishes each started cycle after a set delay.
`timescale 1ns/1ps
module ptv_remote_engine (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [3:0] delay_i,
    output logic            done_o
);
    logic       busy_reg;
    logic [3:0] count_reg;
    // Done is never raised without a start, so a slow or prompt far side can be chosen.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy_reg <= 1'b0;
            count_reg <= 4'h0;
        end else if (start_i) begin
            busy_reg <= 1'b1;
            count_reg <= delay_i;
        end else if (busy_reg && count_reg == 4'h0) begin
            busy_reg <= 1'b0;
            done_o <= 1'b1;
        end else if (busy_reg) begin
            count_reg <= count_reg - 4'h1;
        end
    end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the third PCI target image.
`timescale 1ns/1ps
module tb;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'hf, dly = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, req_addr_i = 32'h0, wb_dat_o, vme_addr_o, rd;
    logic        req_valid_i = 0, req_io_i = 0, req_write_i = 0, vme_done_i, io, w, pst;
    logic        wb_ack_o, req_ready_o, pci_claim_o, pci_miss_o, pci_done_o, vme_start_o;
    logic        vme_write_o, vme_program_o, vme_super_o, vme_blt_o, vme_mblt_o, vme_posted_o;
    logic [2:0]  vme_space_o;
    logic [1:0]  vme_width_o;
    integer      miscompares = 0, n_compared = 0, cyc = 0, seed = 32'h4c468915;
    integer      i, n, a, ctl, bs, lim, ofs, hi, ab, w3;
    always #5 clk_i = ~clk_i;
    ptv_image3 i_ptv_image3 (.*);
    ptv_remote_engine i_ptv_remote_engine (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(vme_start_o), .delay_i(dly), .done_o(vme_done_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Classic single cycle; the slave's outputs are read at the edge, before it updates them.
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        // A slave that never answers is caught by the cycle ceiling below.
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pci(input logic [31:0] adr, input logic sp, input logic wr);
        req_valid_i <= 1'b1;
        req_addr_i <= adr;
        req_io_i <= sp;
        req_write_i <= wr;
        do begin
            @(posedge clk_i);
        end while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 6; i++) begin
            wb(1'b0, 12'h13c + 12'(4 * i), 32'h0);
            chk("reset value", rd, i == 0 ? 32'h0080_0000 : 32'h0);
        end
        for (i = 0; i < 4; i++) begin
            wb(1'b1, 12'h13c + 12'(4 * i), 32'hffff_ffff);
            wb(1'b0, 12'h13c + 12'(4 * i), 32'h0);
            chk("writable bits", rd, i == 0 ? 32'hc0c7_5101 : 32'hffff_0000);
        end
        // Only the enabled byte lane may change the stored window base.
        wb_sel_i <= 4'h4;
        wb(1'b1, 12'h140, 32'h1234_5678);
        wb_sel_i <= 4'hf;
        wb(1'b0, 12'h140, 32'h0);
        chk("byte lanes", rd, 32'hff34_0000);
        // Every space code and width; the window is probed just below, at and past its ends.
        for (i = 0; i < 64; i++) begin
            ctl = ($random(seed) & 32'h4000_5101) | ((i % 5 != 0) << 31);
            ctl = ctl | ((i / 8 % 4) << 22) | ((i % 8) << 16);
            bs = $random(seed) & 32'hffff;
            lim = (i % 4 == 0) ? 0 : (bs + 2) & 32'hffff;
            ofs = $random(seed) & 32'hffff;
            hi = (bs - 1 + {$random(seed)} % 4) & 32'hffff;
            a = (hi << 16) | ($random(seed) & 32'hffff);
            io = ctl[0] ^ (i % 7 == 0);
            w = $random(seed);
            dly <= 4'({$random(seed)} % 5);
            wb(1'b1, 12'h13c, ctl);
            wb(1'b1, 12'h140, bs << 16);
            wb(1'b1, 12'h144, lim << 16);
            wb(1'b1, 12'h148, ofs << 16);
            n = ctl[31] && io == ctl[0] && hi >= bs && (lim == 0 || hi < lim);
            pci(a, io, w);
            chk("claim", {pci_claim_o, pci_miss_o}, {n[0], !n[0]});
            if (n) begin
                ab = i % 8 == 1 || i % 8 == 2;
                w3 = ctl[23:22] == 2'h3;
                pst = w && ctl[30] && !ctl[0];
                chk("address", vme_addr_o, ((hi + ofs) << 16) | (a & 32'hffff));
                chk("attributes", {vme_space_o, vme_width_o, vme_program_o,
                    vme_super_o, vme_write_o}, {ctl[18:16], ctl[23:22], ctl[14], ctl[12], w});
                chk("block", {vme_blt_o, vme_mblt_o}, {ctl[8] && ab && !w3, ab && w3});
                chk("posted", {vme_posted_o, pci_done_o}, {pst, pst});
                n = 0;
                do begin
                    @(posedge clk_i);
                    n += (pci_done_o === 1'b1);
                end while (req_ready_o !== 1'b1);
                chk("late done", n, !pst);
            end
        end
        end_sim();
    end
endmodule
